//--- ilod_data_ram.sv
// Byte-wide data memory with a registered read port for the operand path
`timescale 1ns/10ps

module ilod_data_ram #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // Clock
  input  wire logic              pclk,
  // Single access port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial begin
    if (ADDR_W < 1 || DATA_W < 1) begin
      $error("ilod_data_ram: widths must be positive");
    end
  end

  // Read-during-write returns the old byte; the core never relies on either
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule

//--- ilod_decode.sv
// Package and top module of the indexed literal offset operand decoder
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps

package ilod_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on APB
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ILOD_OFS_CTRL    = 8'h00;
  localparam logic [7:0] ILOD_OFS_PTR     = 8'h04;
  localparam logic [7:0] ILOD_OFS_BANK    = 8'h08;
  localparam logic [7:0] ILOD_OFS_WREG    = 8'h0C;
  localparam logic [7:0] ILOD_OFS_INSTR   = 8'h10;
  localparam logic [7:0] ILOD_OFS_STATUS  = 8'h14;
  localparam logic [7:0] ILOD_OFS_EADDR   = 8'h18;
  localparam logic [7:0] ILOD_OFS_MEMADDR = 8'h1C;
  localparam logic [7:0] ILOD_OFS_MEMDATA = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int ILOD_CTRL_EXT     = 0;  // extended_set_enable_bit
  localparam int ILOD_ST_C         = 0;
  localparam int ILOD_ST_DC        = 1;
  localparam int ILOD_ST_Z         = 2;
  localparam int ILOD_ST_OV        = 3;
  localparam int ILOD_ST_N         = 4;
  localparam int ILOD_ST_BUSY      = 8;
  localparam int ILOD_ST_ILLEGAL   = 9;
  localparam int ILOD_EADDR_INDEX  = 16; // last operand went through the pointer

  // ---------------------------------------------------------------------------
  // Opcode layout and patterns
  // ---------------------------------------------------------------------------
  // Only the operation field is matched; d, a, b and the operand ride below it
  // A code that matches none of these is stored but never executed
  localparam logic [5:0] ILOD_OP_ADD     = 6'b0010_01;  // add_wreg_to_file, bits 15:10
  localparam logic [3:0] ILOD_OP_BSET    = 4'b1000;     // bit_set_file, bits 15:12
  localparam logic [6:0] ILOD_OP_SETALL  = 7'b0110_100; // set_file_all_ones, bits 15:9
  localparam int         ILOD_BIT_D      = 9;
  localparam int         ILOD_BIT_A      = 8;

  // ---------------------------------------------------------------------------
  // Addressing constants and reset values
  // ---------------------------------------------------------------------------
  // Operands above the boundary keep their literal meaning in either mode
  localparam logic [7:0]  ILOD_OFFSET_MAX = 8'h5F;   // highest redirected operand
  localparam logic [3:0]  ILOD_ACC_HI     = 4'hF;    // upper access-bank page
  localparam logic [7:0]  ILOD_ALL_ONES   = 8'hFF;
  localparam logic [31:0] ILOD_RESET_WORD = 32'h0000_0000;

  // Execution phases, Gray coded along the usual path
  typedef enum logic [1:0] {
    ILOD_IDLE  = 2'b00,
    ILOD_READ  = 2'b01,
    ILOD_PROC  = 2'b11,
    ILOD_WRITE = 2'b10
  } ilod_state_t;

endpackage

// Notes on behaviour
// - Extension off: literal address, access bank when a=0, banked when a=1.
// - Extension on, a=0, operand at most 5Fh: address is pointer plus operand.
// - Extension on, operands above 5Fh keep ordinary literal addressing.
// - Pointer at 00h makes indexed operands land on legacy access RAM locations.
// - Indexed forms carry access bit 0, so redirection applies whenever the extension is on and the operand is at most 5Fh.
// - Indexed add puts working register plus addressed byte; one word, one cycle (the core takes three: read, process, write).
// - Add updates negative, overflow, carry, digit carry and zero flags.
// - Destination bit 0 writes working register, 1 writes the file byte.
// - Indexed bit set sets bit 0..7 of addressed byte, flags untouched.
// - Indexed set-all writes FFh to addressed byte, flags untouched.
// - Extension enable bit 0 disables indexed offset addressing entirely.
module ilod_decode import ilod_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int BANK_W = ADDR_W - 8;

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The bank field needs at least one bit and the address field of EADDR ends below the index flag at bit 16
  initial begin
    if (ADDR_W < 9 || ADDR_W > 16) begin
      $error("ilod_decode: ADDR_W must lie between 9 and 16");
    end
  end

  // ---------------------------------------------------------------------------
  // State of the block
  // ---------------------------------------------------------------------------
  // Execution phase first, then architectural registers, execution scratch and the bus answer;
  // one register for all of it, so reset clears every field at once
  typedef struct packed {
    ilod_state_t       state;
    logic              ext_en;
    logic [ADDR_W-1:0] pointer;
    logic [BANK_W-1:0] bank;
    logic [7:0]        wreg;
    logic [15:0]       opcode;
    logic [4:0]        flags;
    logic              illegal;
    logic              indexed;
    logic [ADDR_W-1:0] eaddr;
    logic [7:0]        result;
    logic              to_file;
    logic [ADDR_W-1:0] mem_addr;
    logic              settled;
    logic              ready;
    logic              slverr;
    logic [31:0]       rdata;
  } ilod_regs_t;

  ilod_regs_t cur;
  ilod_regs_t next_cur;

  logic              ram_we;
  logic [ADDR_W-1:0] ram_addr;
  logic [7:0]        ram_wdata;
  logic [7:0]        ram_rdata;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  // True when an operand is redirected through the pointer
  function automatic logic is_indexed(input logic ext, input logic acc, input logic [7:0] f);
    return ext && !acc && (f <= ILOD_OFFSET_MAX);
  endfunction

  // Effective data address of a byte or bit operand
  function automatic logic [ADDR_W-1:0] eff_addr(input logic              ext,
                                                 input logic              acc,
                                                 input logic [7:0]        f,
                                                 input logic [ADDR_W-1:0] ptr,
                                                 input logic [BANK_W-1:0] bnk);
    logic [ADDR_W-1:0] page_hi;
    // Upper access page: every bit above the low byte set, low byte clear, so
    // an operand above the boundary lands in the top 256 bytes of data space
    page_hi = {{(ADDR_W-8){1'b1}}, 8'h00} | ADDR_W'({ILOD_ACC_HI, 8'h00});
    if (is_indexed(ext, acc, f)) begin
      return ptr + ADDR_W'(f);
    end else if (acc) begin
      return {bnk, f};
    end else if (f <= ILOD_OFFSET_MAX) begin
      return ADDR_W'(f);
    end else begin
      return page_hi | ADDR_W'(f);
    end
  endfunction

  // Opcode class tests, shared by the legality check and the execute phase
  function automatic logic is_add(input logic [15:0] op);
    return op[15:10] == ILOD_OP_ADD;
  endfunction

  function automatic logic is_bset(input logic [15:0] op);
    return op[15:12] == ILOD_OP_BSET;
  endfunction

  function automatic logic is_setall(input logic [15:0] op);
    return op[15:9] == ILOD_OP_SETALL;
  endfunction

  // True when the opcode is one of the three decoded operations
  function automatic logic is_known(input logic [15:0] op);
    return is_add(op) || is_bset(op) || is_setall(op);
  endfunction

  // ---------------------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------------------
  ilod_data_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (8)
  ) u_ram (
    .pclk    (pclk),
    .addr    (ram_addr),
    .wr_en   (ram_we),
    .wr_data (ram_wdata),
    .rd_data (ram_rdata)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic: APB slave and execution phases
  // ---------------------------------------------------------------------------
  always_comb begin
    logic       access;
    logic       commit;
    logic       mapped;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] opnd;
    next_cur  = cur;
    access    = psel && penable;
    commit    = access && cur.ready;
    mapped    = 1'b0;
    sum       = 9'h000;
    low       = 5'h00;
    opnd      = ram_rdata;
    ram_we    = 1'b0;
    ram_addr  = cur.mem_addr;
    ram_wdata = pwdata[7:0];

    // Ready pulses for one cycle, then the bus is released
    // Read data drop with it, so the bus shows zero between answers
    if (cur.ready) begin
      next_cur.ready  = 1'b0;
      next_cur.slverr = 1'b0;
      next_cur.rdata  = ILOD_RESET_WORD;
    end

    unique case (cur.state)
      ILOD_IDLE: begin
        // Read data of the memory are trusted one cycle after leaving execution
        next_cur.settled = 1'b1;
      end
      ILOD_READ: begin
        // Present the operand address; the byte comes out registered next cycle
        ram_addr      = cur.eaddr;
        next_cur.state = ILOD_PROC;
      end
      ILOD_PROC: begin
        ram_addr = cur.eaddr;
        // Only known codes ever reach this phase, so the last branch is set-all
        if (is_add(cur.opcode)) begin
          sum  = {1'b0, cur.wreg} + {1'b0, opnd};
          low  = {1'b0, cur.wreg[3:0]} + {1'b0, opnd[3:0]};
          next_cur.result          = sum[7:0];
          next_cur.flags[ILOD_ST_C]  = sum[8];
          next_cur.flags[ILOD_ST_DC] = low[4];
          next_cur.flags[ILOD_ST_Z]  = (sum[7:0] == 8'h00);
          next_cur.flags[ILOD_ST_N]  = sum[7];
          next_cur.flags[ILOD_ST_OV] = (cur.wreg[7] == opnd[7]) && (sum[7] != opnd[7]);
          next_cur.to_file = cur.opcode[ILOD_BIT_D];
        end else if (is_bset(cur.opcode)) begin
          next_cur.result  = opnd | (8'h01 << cur.opcode[11:9]);
          next_cur.to_file = 1'b1;
        end else begin
          next_cur.result  = ILOD_ALL_ONES;
          next_cur.to_file = 1'b1;
        end
        next_cur.state = ILOD_WRITE;
      end
      ILOD_WRITE: begin
        ram_addr  = cur.eaddr;
        ram_wdata = cur.result;
        ram_we    = cur.to_file;
        if (!cur.to_file) begin
          next_cur.wreg = cur.result;
        end
        next_cur.state   = ILOD_IDLE;
        // The next bus answer waits one cycle for fresh memory read data
        next_cur.settled = 1'b0;
      end
    endcase

    // Access phase: answered only when idle, so execution stalls register traffic
    // Trade-off: one wait state on every transfer buys a registered answer
    // and keeps bus writes from racing an opcode that is still in flight
    if (access && !cur.ready && cur.state == ILOD_IDLE && cur.settled) begin
      mapped = 1'b1;
      unique case (paddr)
        ILOD_OFS_CTRL:    next_cur.rdata = 32'(cur.ext_en);
        ILOD_OFS_PTR:     next_cur.rdata = 32'(cur.pointer);
        ILOD_OFS_BANK:    next_cur.rdata = 32'(cur.bank);
        ILOD_OFS_WREG:    next_cur.rdata = 32'(cur.wreg);
        ILOD_OFS_INSTR:   next_cur.rdata = 32'(cur.opcode);
        ILOD_OFS_STATUS:  next_cur.rdata = 32'(cur.flags) | (32'(cur.illegal) << ILOD_ST_ILLEGAL);
        ILOD_OFS_EADDR:   next_cur.rdata = 32'(cur.eaddr) | (32'(cur.indexed) << ILOD_EADDR_INDEX);
        ILOD_OFS_MEMADDR: next_cur.rdata = 32'(cur.mem_addr);
        ILOD_OFS_MEMDATA: next_cur.rdata = 32'(ram_rdata);
        default: begin
          mapped         = 1'b0;
          next_cur.rdata = ILOD_RESET_WORD;
        end
      endcase
      if (pwrite) begin
        next_cur.rdata = ILOD_RESET_WORD;
      end
      next_cur.ready  = 1'b1;
      next_cur.slverr = !mapped;
    end

    // Writes take effect at the edge where the master sees ready
    // A refused transfer changes nothing, not even the memory
    if (commit && pwrite && !cur.slverr) begin
      unique case (paddr)
        ILOD_OFS_CTRL:    next_cur.ext_en   = pwdata[ILOD_CTRL_EXT];
        ILOD_OFS_PTR:     next_cur.pointer  = pwdata[ADDR_W-1:0];
        ILOD_OFS_BANK:    next_cur.bank     = pwdata[BANK_W-1:0];
        ILOD_OFS_WREG:    next_cur.wreg     = pwdata[7:0];
        ILOD_OFS_MEMADDR: next_cur.mem_addr = pwdata[ADDR_W-1:0];
        ILOD_OFS_MEMDATA: ram_we            = 1'b1;
        ILOD_OFS_INSTR: begin
          next_cur.opcode  = pwdata[15:0];
          next_cur.illegal = !is_known(pwdata[15:0]);
          next_cur.indexed = is_indexed(cur.ext_en, pwdata[ILOD_BIT_A], pwdata[7:0]);
          next_cur.eaddr   = eff_addr(cur.ext_en, pwdata[ILOD_BIT_A], pwdata[7:0],
                                      cur.pointer, cur.bank);
          if (is_known(pwdata[15:0])) begin
            next_cur.state = ILOD_READ;
          end
        end
        default: begin
          next_cur.rdata = cur.rdata;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  // No logic follows the flops, so the bus sees clean edges
  assign prdata  = cur.rdata;
  assign pready  = cur.ready;
  assign pslverr = cur.slverr;

endmodule

//--- ilod_decode_props.sv
// Concurrent checks on the register port of the operand decoder
`timescale 1ns/10ps

module ilod_decode_props import ilod_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Enable bit as it stood when the last opcode was committed
  logic ext_q;
  logic ext_i;
  logic done_w;
  logic mapped;
  assign done_w = psel && penable && pready && pwrite;
  assign mapped = (paddr <= ILOD_OFS_MEMDATA) && (paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
      ext_i <= 1'b0;
    end else begin
      if (done_w && paddr == ILOD_OFS_CTRL) ext_q <= pwdata[ILOD_CTRL_EXT];
      if (done_w && paddr == ILOD_OFS_INSTR) ext_i <= ext_q;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_read_of(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  a_first_access_waits: assert property (s_setup_access |-> !pready)
    else $error("ready in first access cycle");
  a_answer_bounded: assert property (psel && penable && !pready |-> ##[1:8] pready)
    else $error("no answer within eight cycles");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  a_mapped_no_err: assert property (pready && mapped |-> !pslverr)
    else $error("mapped address refused");
  a_idle_quiet: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  a_err_with_ready: assert property (!pready |-> !pslverr)
    else $error("error flag outside an answer");
  a_status_fields: assert property (s_read_of(ILOD_OFS_STATUS) |-> prdata[8:5] == 4'h0)
    else $error("status reserved bits set");
  a_ext_gates_index: assert property (s_read_of(ILOD_OFS_EADDR) ##0 !ext_i |->
    !prdata[ILOD_EADDR_INDEX] && prdata[15:ADDR_W] == '0)
    else $error("indexed address with extension off");
endmodule

//--- indexed_literal_offset_decode_tb_top.sv
// Self-checking bench of the operand decoder over its register port
`timescale 1ns/10ps

module indexed_literal_offset_decode_tb_top import ilod_pkg::*;;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          miscompares;
  int          total_checks;

  ilod_decode #(.ADDR_W(12)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds everything until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic exec(input logic [15:0] op);
    wr(ILOD_OFS_INSTR, {16'h0000, op});
  endtask

  task automatic mem_set(input logic [11:0] a, input logic [7:0] v);
    wr(ILOD_OFS_MEMADDR, {20'h0_0000, a});
    wr(ILOD_OFS_MEMDATA, {24'h00_0000, v});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
    wr(ILOD_OFS_MEMADDR, {20'h0_0000, a});
    rd_chk(ILOD_OFS_MEMDATA, {24'h00_0000, v});
  endtask

  // Run one set-all opcode and compare the resolved address
  task automatic ea(input logic a, input logic [7:0] f, input logic [31:0] exp);
    exec({ILOD_OP_SETALL, a, f});
    rd_chk(ILOD_OFS_EADDR, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_legacy;
    rd_chk(ILOD_OFS_CTRL, 32'h0000_0000);
    rd_chk(ILOD_OFS_STATUS, 32'h0000_0000);
    wr(ILOD_OFS_PTR, 32'h0000_0A00);
    wr(ILOD_OFS_BANK, 32'h0000_0005);
    ea(1'b0, 8'h2C, 32'h0000_002C);
    mem_chk(12'h02C, 8'hFF);
    ea(1'b0, 8'h80, 32'h0000_0F80);
    ea(1'b1, 8'h30, 32'h0000_0530);
    $display("legacy addressing done");
  endtask

  task automatic t_index;
    wr(ILOD_OFS_CTRL, 32'h0000_0001);
    mem_set(12'hA2C, 8'h00);
    ea(1'b0, 8'h2C, 32'h0001_0A2C);
    mem_chk(12'hA2C, 8'hFF);
    ea(1'b0, 8'h5F, 32'h0001_0A5F);
    ea(1'b0, 8'h60, 32'h0000_0F60);
    ea(1'b1, 8'h10, 32'h0000_0510);
    wr(ILOD_OFS_PTR, 32'h0000_0FF0);
    ea(1'b0, 8'h20, 32'h0001_0010);
    wr(ILOD_OFS_PTR, 32'h0000_0000);
    ea(1'b0, 8'h15, 32'h0001_0015);
    wr(ILOD_OFS_PTR, 32'h0000_0A00);
    $display("indexed addressing done");
  endtask

  task automatic t_add;
    logic [7:0] w_in[3] = '{8'h80, 8'h08, 8'h40};
    logic [7:0] st[3] = '{8'h0D, 8'h02, 8'h18};
    mem_set(12'hA2C, 8'h20);
    wr(ILOD_OFS_WREG, 32'h0000_0017);
    exec({ILOD_OP_ADD, 1'b0, 1'b0, 8'h2C});
    rd_chk(ILOD_OFS_WREG, 32'h0000_0037);
    mem_chk(12'hA2C, 8'h20);
    exec({ILOD_OP_ADD, 1'b1, 1'b0, 8'h2C});
    mem_chk(12'hA2C, 8'h57);
    rd_chk(ILOD_OFS_WREG, 32'h0000_0037);
    for (int i = 0; i < 3; i++) begin
      mem_set(12'hA2C, w_in[i]);
      wr(ILOD_OFS_WREG, {24'h00_0000, w_in[i]});
      exec({ILOD_OP_ADD, 1'b0, 1'b0, 8'h2C});
      rd_chk(ILOD_OFS_STATUS, {24'h00_0000, st[i]});
    end
    $display("indexed add done");
  endtask

  task automatic t_bset;
    for (int b = 0; b < 8; b++) begin
      mem_set(12'hA0A, 8'h55);
      exec({ILOD_OP_BSET, 3'(b), 1'b0, 8'h0A});
      mem_chk(12'hA0A, 8'h55 | (8'h01 << b));
    end
    rd_chk(ILOD_OFS_STATUS, 32'h0000_0018);
    exec({ILOD_OP_SETALL, 1'b0, 8'h0A});
    rd_chk(ILOD_OFS_STATUS, 32'h0000_0018);
    $display("bit set and set all done");
  endtask

  task automatic t_refused;
    logic [31:0] r;
    logic        e;
    xfer(1'b0, 8'h24, 32'h0, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    exec(16'hFFFF);
    rd_chk(ILOD_OFS_STATUS, 32'h0000_0218);
    $display("refusals done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_legacy();
    t_index();
    t_add();
    t_bset();
    t_refused();
    end_sim();
  end

  // Roughly 100 transfers of under ten cycles each fit well inside this
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
endmodule

bind ilod_decode ilod_decode_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
